//--- logic/lpc_flash_front.sv
// Host-interface front end of the flash: serial nibble bus and parallel port.
// Assumes an array core behind it that runs program/erase and reports busy.
`timescale 1ns/1ps
module lpc_flash_front
	import lpc_flash_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic init_n,
	input wire logic mode_select,
	input wire logic [ID_W-1:0] strap_identity_inputs,
	input wire logic [GPI_W-1:0] general_purpose_inputs,
	input wire logic top_block_lock_n,
	input wire logic write_protect_n,
	input wire logic [NUM_BLK-1:0] block_lock_bits,
	input wire logic lclk,
	input wire logic lframe_n,
	input wire logic [3:0] lad_in,
	output logic [3:0] lad_out,
	output logic lad_oe_n,
	input wire logic [MUX_AW-1:0] multiplexed_address_port,
	input wire logic row_col_select,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] parallel_data_in,
	output logic [7:0] parallel_data_out,
	output logic parallel_data_oe_n,
	output logic ready_busy_n,
	output logic array_rd_req,
	output logic array_wr_req,
	output logic [ARRAY_AW-1:0] array_addr,
	output logic [7:0] array_wr_data,
	input wire logic [7:0] array_rd_data,
	input wire logic array_rd_valid,
	input wire logic array_busy,
	output logic chip_erase_allowed,
	output logic write_rejected,
	output logic standby,
	output logic ready_state,
	output logic boot_device,
	output logic mux_mode
);

	// ******************************
	// Reset, strap and protection
	// ******************************
	logic dev_rst_n;
	logic write_allowed;
	logic [BLK_W-1:0] guard_blk;

	mode_strap_reset u_reset (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.init_n(init_n),
		.mode_select(mode_select),
		.dev_rst_n(dev_rst_n),
		.mux_mode(mux_mode)
	);

	write_guard u_guard (
		.mux_mode(mux_mode),
		.top_block_lock_n(top_block_lock_n),
		.write_protect_n(write_protect_n),
		.block_lock_bits(block_lock_bits),
		.target_blk(guard_blk),
		.write_allowed(write_allowed)
	);

	// ******************************
	// Bus clock edge detect
	// ******************************
	logic lclk_prev_r;
	logic lclk_rise;

	// Bus clock treated as a sampled input; one ref_clk pulse per rising edge in serial mode
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			lclk_prev_r <= 1'b1;
		end else begin
			lclk_prev_r <= lclk;
		end
	end

	assign lclk_rise = lclk & ~lclk_prev_r & ~mux_mode;

	// ******************************
	// Host-bus cycle sequencer
	// ******************************
	host_state_e state_r;
	host_state_e state_nxt;
	logic [2:0] nib_cnt_r;
	logic [HOST_AW-1:0] addr_r;
	logic dir_write_r;
	logic [7:0] data_r;
	logic data_ready_r;
	logic addr_hit;
	logic to_array;

	// Identity match and space select on the completed address
	assign addr_hit = (addr_r[ID_LSB +: ID_W] == strap_identity_inputs);
	assign to_array = addr_r[SPACE_BIT];
	assign boot_device = (strap_identity_inputs == STRAP_BOOT_ID);

	// Next state on each bus clock edge; frame low always re-arbitrates
	always_comb begin
		state_nxt = state_r;
		if (!lframe_n) begin
			if (lad_in == NIB_START) begin
				state_nxt = ST_CYC;
			end else if (lad_in == NIB_ABORT || state_r == ST_IDLE) begin
				state_nxt = ST_IDLE;
			end else begin
				state_nxt = ST_ABORT;
			end
		end else begin
			unique case (state_r)
				ST_IDLE: state_nxt = ST_IDLE;
				ST_ABORT: state_nxt = ST_ABORT;
				ST_CYC: begin
					if (lad_in[CYC_TYPE_MSB -: 2] == CYC_MEMORY) begin
						state_nxt = ST_ADDR;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
				ST_ADDR: begin
					if (nib_cnt_r != ADDR_LAST_NIB) begin
						state_nxt = ST_ADDR;
					end else if (dir_write_r) begin
						state_nxt = ST_WDAT0;
					end else begin
						state_nxt = ST_TAR0;
					end
				end
				ST_WDAT0: state_nxt = ST_WDAT1;
				ST_WDAT1: state_nxt = ST_TAR0;
				ST_TAR0: begin
					// A foreign identity is left alone: no turnaround, no sync
					if (addr_hit) begin
						state_nxt = ST_TAR1;
					end else begin
						state_nxt = ST_IDLE;
					end
				end
				ST_TAR1: state_nxt = ST_SYNC;
				ST_SYNC: begin
					if (lad_out != NIB_SYNC_OK) begin // Ready nibble not yet shown
						state_nxt = ST_SYNC;
					end else if (dir_write_r) begin
						state_nxt = ST_ETAR0;
					end else begin
						state_nxt = ST_RDAT0;
					end
				end
				ST_RDAT0: state_nxt = ST_RDAT1;
				ST_RDAT1: state_nxt = ST_ETAR0;
				ST_ETAR0: state_nxt = ST_ETAR1;
				ST_ETAR1: state_nxt = ST_IDLE;
				default: state_nxt = ST_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			state_r <= ST_IDLE;
		end else if (lclk_rise) begin
			state_r <= state_nxt;
		end
	end

	// Direction bit and address nibbles, most significant first
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			nib_cnt_r <= 3'h0;
			addr_r <= '0;
			dir_write_r <= 1'b0;
		end else if (lclk_rise) begin
			if (state_r == ST_CYC) begin
				dir_write_r <= lad_in[CYC_DIR_BIT];
				nib_cnt_r <= 3'h0;
			end
			if (state_r == ST_ADDR && lframe_n) begin
				addr_r <= {addr_r[HOST_AW-5:0], lad_in};
				nib_cnt_r <= nib_cnt_r + 3'h1;
			end
		end
	end

	// ******************************
	// Data path and array requests
	// ******************************
	logic wr_cmd_pulse;
	logic rd_cmd_pulse;
	logic reg_read;

	// Issue at the edge that leaves ST_TAR0, one bus clock after the last data or address nibble
	assign wr_cmd_pulse = lclk_rise & lframe_n & (state_r == ST_TAR0) & addr_hit
		& dir_write_r & to_array;
	assign rd_cmd_pulse = lclk_rise & lframe_n & (state_r == ST_TAR0) & addr_hit
		& ~dir_write_r & to_array;
	assign reg_read = lclk_rise & lframe_n & (state_r == ST_TAR1) & ~dir_write_r & ~to_array;

	// Write data nibbles arrive low nibble first; read data lands from array or register
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			data_r <= DATA_RESET;
			data_ready_r <= 1'b0;
		end else begin
			if (lclk_rise && lframe_n && state_r == ST_WDAT0) begin
				data_r[3:0] <= lad_in;
			end
			if (lclk_rise && lframe_n && state_r == ST_WDAT1) begin
				data_r[7:4] <= lad_in;
			end
			if (lclk_rise && state_r == ST_TAR0) begin
				// Writes are posted, so their sync never waits
				data_ready_r <= dir_write_r;
			end
			if (reg_read) begin
				data_ready_r <= 1'b1;
				if (addr_r[REG_OFS_W-1:0] == GPI_REG_OFS) begin
					data_r <= {{(8-GPI_W){1'b0}}, general_purpose_inputs};
				end else begin
					data_r <= REG_UNMAPPED;
				end
			end
			if (array_rd_valid && !mux_mode) begin
				data_r <= array_rd_data;
				data_ready_r <= 1'b1;
			end
		end
	end

	// Host-bus output nibble and drive enable, set for the coming bus clock
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			lad_out <= NIB_TURN;
			lad_oe_n <= 1'b1;
		end else if (lclk_rise) begin
			lad_out <= NIB_TURN;
			lad_oe_n <= 1'b1;
			unique case (state_nxt)
				ST_TAR1, ST_ETAR0: lad_oe_n <= 1'b0;
				ST_SYNC: begin
					lad_oe_n <= 1'b0;
					lad_out <= data_ready_r ? NIB_SYNC_OK : NIB_SYNC_WAIT;
				end
				ST_RDAT0: begin
					lad_oe_n <= 1'b0;
					lad_out <= data_r[3:0];
				end
				ST_RDAT1: begin
					lad_oe_n <= 1'b0;
					lad_out <= data_r[7:4];
				end
				default: lad_oe_n <= 1'b1;
			endcase
		end
	end

	// ******************************
	// Parallel programming port
	// ******************************
	logic [MUX_AW-1:0] row_r;
	logic [COL_W-1:0] col_r;
	logic we_prev_r;
	logic oe_prev_r;
	logic mux_wr_pulse;
	logic mux_rd_pulse;
	logic [ARRAY_AW-1:0] mux_addr;

	// Row half while select is high, column half while low
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			row_r <= '0;
			col_r <= '0;
		end else if (mux_mode) begin
			if (row_col_select) begin
				row_r <= multiplexed_address_port;
			end else begin
				col_r <= multiplexed_address_port[COL_W-1:0];
			end
		end
	end

	assign mux_addr = {col_r, row_r};

	// Strobe edges: write on rising write enable, read on falling output enable
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			we_prev_r <= 1'b1;
			oe_prev_r <= 1'b1;
		end else begin
			we_prev_r <= we_n;
			oe_prev_r <= oe_n;
		end
	end

	assign mux_wr_pulse = mux_mode & we_n & ~we_prev_r;
	assign mux_rd_pulse = mux_mode & ~oe_n & oe_prev_r;

	// Read data held on the port until the next read
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			parallel_data_out <= DATA_RESET;
		end else if (mux_mode && array_rd_valid) begin
			parallel_data_out <= array_rd_data;
		end
	end

	assign parallel_data_oe_n = ~(mux_mode & ~oe_n);

	// ******************************
	// Array request arbitration
	// ******************************
	// The strap picks one side, so the two sources never meet
	assign guard_blk = mux_mode ? mux_addr[BLK_LSB +: BLK_W] : addr_r[BLK_LSB +: BLK_W];

	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n) begin
			array_rd_req <= 1'b0;
			array_wr_req <= 1'b0;
			array_addr <= '0;
			array_wr_data <= DATA_RESET;
			write_rejected <= 1'b0;
		end else begin
			array_rd_req <= rd_cmd_pulse | mux_rd_pulse;
			array_wr_req <= (wr_cmd_pulse | mux_wr_pulse) & write_allowed;
			write_rejected <= (wr_cmd_pulse | mux_wr_pulse) & ~write_allowed;
			if (mux_rd_pulse || mux_wr_pulse) begin
				array_addr <= mux_addr;
			end else if (rd_cmd_pulse || wr_cmd_pulse) begin
				array_addr <= addr_r[ARRAY_AW-1:0];
			end
			if (mux_wr_pulse) begin
				array_wr_data <= parallel_data_in;
			end else if (wr_cmd_pulse) begin
				array_wr_data <= data_r;
			end
		end
	end

	// ******************************
	// Status outputs
	// ******************************
	// Whole-chip erase may only be decoded by the core in parallel mode
	assign chip_erase_allowed = mux_mode;

	// Busy line means nothing in serial mode, so it idles at ready there
	assign ready_busy_n = ~(mux_mode & array_busy);

	// Standby needs both a quiet frame and a quiet core; abort leaves the core running
	assign standby = ~mux_mode & lframe_n & ~array_busy;
	assign ready_state = ~mux_mode & ~lframe_n & (state_r == ST_IDLE);

endmodule

//--- logic/lpc_flash_pkg.sv
// Constants and types shared by the flash host-interface front end.
// Assumes one system clock; all pins arrive synchronous to it.
package lpc_flash_pkg;

	// ******************************
	// Host-bus nibble codes
	// ******************************
	localparam logic [3:0] NIB_START = 4'h0;
	localparam logic [3:0] NIB_ABORT = 4'hf;
	localparam logic [3:0] NIB_SYNC_OK = 4'h0;
	localparam logic [3:0] NIB_SYNC_WAIT = 4'h5;
	localparam logic [3:0] NIB_TURN = 4'hf;
	localparam logic [1:0] CYC_MEMORY = 2'b01;
	localparam int CYC_TYPE_MSB = 3;
	localparam int CYC_DIR_BIT = 1;

	// ******************************
	// Address layout
	// ******************************
	localparam int HOST_AW = 32;
	localparam logic [2:0] ADDR_LAST_NIB = 3'h7;
	localparam int SPACE_BIT = 22;
	localparam int ID_LSB = 23;
	localparam int ID_W = 4;
	localparam int ARRAY_AW = 19;
	localparam int BLK_LSB = 16;
	localparam int BLK_W = 3;
	localparam int NUM_BLK = 8;
	localparam logic [BLK_W-1:0] BOOT_BLK = 3'h7;
	localparam int MUX_AW = 11;
	localparam int COL_W = 8;
	localparam int REG_OFS_W = 8;
	localparam logic [REG_OFS_W-1:0] GPI_REG_OFS = 8'h00;

	// ******************************
	// Straps, inputs and reset values
	// ******************************
	localparam logic [ID_W-1:0] STRAP_BOOT_ID = 4'h0;
	localparam int GPI_W = 5;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] REG_UNMAPPED = 8'h00;

	// ******************************
	// Host-bus cycle states
	// ******************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CYC = 4'h1,
		ST_ADDR = 4'h2,
		ST_WDAT0 = 4'h3,
		ST_WDAT1 = 4'h4,
		ST_TAR0 = 4'h5,
		ST_TAR1 = 4'h6,
		ST_SYNC = 4'h7,
		ST_RDAT0 = 4'h8,
		ST_RDAT1 = 4'h9,
		ST_ETAR0 = 4'ha,
		ST_ETAR1 = 4'hb,
		ST_ABORT = 4'hc
	} host_state_e;

endpackage

//--- logic/mode_strap_reset.sv
// Reset combiner and interface-select strap capture.
// Assumes both reset pins are synchronous to ref_clk and active low.
`timescale 1ns/1ps
module mode_strap_reset
	import lpc_flash_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic init_n,
	input wire logic mode_select,
	output logic dev_rst_n,
	output logic mux_mode
);

	logic dev_rst_n_r;
	logic mux_mode_r;

	// Either pin low resets the device
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			dev_rst_n_r <= 1'b0;
		end else begin
			dev_rst_n_r <= init_n;
		end
	end

	// Strap tracked while in reset, frozen once running; a change later is ignored
	always_ff @(posedge ref_clk) begin
		if (!dev_rst_n_r) begin
			mux_mode_r <= mode_select;
		end
	end

	assign dev_rst_n = dev_rst_n_r;
	assign mux_mode = mux_mode_r & dev_rst_n_r;

endmodule

//--- logic/write_guard.sv
// Hardware and register-based write protection per 64 KB block, host-bus mode only.
// Assumes the lock bits come from the device's own lock registers.
`timescale 1ns/1ps
module write_guard
	import lpc_flash_pkg::*;
(
	input wire logic mux_mode,
	input wire logic top_block_lock_n,
	input wire logic write_protect_n,
	input wire logic [NUM_BLK-1:0] block_lock_bits,
	input wire logic [BLK_W-1:0] target_blk,
	output logic write_allowed
);

	logic [NUM_BLK-1:0] blk_open;

	// One term per block; the top block answers to its own pin
	genvar b;
	generate
		for (b = 0; b < NUM_BLK; b++) begin : g_blk
			if (b == BOOT_BLK) begin : g_boot
				assign blk_open[b] = top_block_lock_n & ~block_lock_bits[b];
			end else begin : g_main
				assign blk_open[b] = write_protect_n & ~block_lock_bits[b];
			end
		end
	endgenerate

	// Protection pins belong to the host-bus mode only
	assign write_allowed = mux_mode | blk_open[target_blk];

endmodule

//--- sim/array_core_model.sv
// Array core stand-in: read data after a delay, busy after each write.
// Assumes one-cycle request pulses from the front end on ref_clk.
`timescale 1ns/1ps
module array_core_model (
	input wire logic ref_clk,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic [18:0] addr,
	input wire logic [7:0] delay,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	logic [7:0] rcnt_r = 8'h00;
	logic [7:0] bcnt_r = 8'h00;
	initial rd_data = 8'h00;
	initial rd_valid = 1'b0;
	// ***
	// Answers
	// ***
	// Idle data toggles so a stale byte never reads as a match
	always @(posedge ref_clk) begin
		rd_valid <= rcnt_r == 8'h01;
		rd_data <= (rcnt_r == 8'h01) ? addr[7:0] ^ 8'h5a : ~rd_data;
		rcnt_r <= rd_req ? delay : rcnt_r - 8'((rcnt_r != 8'h00));
		bcnt_r <= wr_req ? delay + 8'h04 : bcnt_r - 8'((bcnt_r != 8'h00));
	end
	assign busy = bcnt_r != 8'h00;
endmodule

//--- sim/lpc_flash_assertions.sv
// Checker for the flash front end, bound to its top ports.
// Assumes ref_clk is the only clock and rst_b the primary reset.
`timescale 1ns/1ps
module lpc_flash_checker
	import lpc_flash_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic init_n,
	input wire logic [ID_W-1:0] strap_identity_inputs,
	input wire logic lframe_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic array_busy,
	input wire logic lad_oe_n,
	input wire logic parallel_data_oe_n,
	input wire logic ready_busy_n,
	input wire logic array_wr_req,
	input wire logic chip_erase_allowed,
	input wire logic write_rejected,
	input wire logic standby,
	input wire logic boot_device,
	input wire logic mux_mode
);
	logic [2:0] up_cnt_r;
	// ***
	// Helpers
	// ***
	// Cycles out of reset, saturating so the strap check waits out release
	always_ff @(posedge ref_clk) begin
		if (!(rst_b && init_n)) begin
			up_cnt_r <= 3'h0;
		end else if (up_cnt_r != 3'h4) begin
			up_cnt_r <= up_cnt_r + 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	chk_boot_identity: assert property (boot_device == (strap_identity_inputs == STRAP_BOOT_ID))
		else $error("boot flag wrong");
	chk_erase_mode_only: assert property (chip_erase_allowed == mux_mode)
		else $error("chip erase outside parallel mode");
	chk_busy_pin: assert property (ready_busy_n == !(mux_mode && array_busy))
		else $error("ready busy wrong");
	chk_standby_idle: assert property (standby == (!mux_mode && lframe_n && !array_busy))
		else $error("standby wrong");
	chk_data_drive: assert property (parallel_data_oe_n == !(mux_mode && !oe_n))
		else $error("data port drive wrong");
	chk_mode_held: assert property (up_cnt_r == 3'h4 |-> $stable(mux_mode))
		else $error("mode moved while running");
	chk_host_pins_quiet: assert property (mux_mode |-> lad_oe_n && !write_rejected)
		else $error("host bus active in parallel mode");
	chk_write_single: assert property ((array_wr_req || write_rejected) |->
		!(array_wr_req && write_rejected) ##1 !array_wr_req && !write_rejected)
		else $error("write pulse malformed");
	chk_strobe_write: assert property (mux_mode && $rose(we_n) |-> ##[1:2] array_wr_req)
		else $error("strobe gave no write");
	chk_init_reset: assert property (!init_n [*3] |-> lad_oe_n && !array_wr_req && !mux_mode)
		else $error("init did not reset");
endmodule
bind lpc_flash_front lpc_flash_checker lpc_flash_checker_inst (.ref_clk(ref_clk),
	.rst_b(rst_b), .init_n(init_n), .strap_identity_inputs(strap_identity_inputs),
	.lframe_n(lframe_n), .oe_n(oe_n), .we_n(we_n), .array_busy(array_busy),
	.lad_oe_n(lad_oe_n), .parallel_data_oe_n(parallel_data_oe_n), .ready_busy_n(ready_busy_n),
	.array_wr_req(array_wr_req), .chip_erase_allowed(chip_erase_allowed),
	.write_rejected(write_rejected), .standby(standby), .boot_device(boot_device),
	.mux_mode(mux_mode));

//--- sim/tb_lpc_flash_front.sv
// Self-checking bench for the flash front end in both interface modes.
// Assumes the bound checker and array_core_model behind the array side.
`timescale 1ns/1ps
module tb_lpc_flash_front;
	import lpc_flash_pkg::*;
	logic ref_clk = 1'b0, rst_b = 1'b0, init_n = 1'b1, msel = 1'b0, lclk = 1'b0, lfr = 1'b1;
	logic rc = 1'b0, oe_n = 1'b1, we_n = 1'b1, tbl = 1'b1, wp = 1'b1;
	logic [3:0] sid = '0, li = '0, lo;
	logic [4:0] gpi = '0;
	logic [7:0] locks = '0, pdi = '0, pdo, rdat, awd, dly = 8'h01, last_d;
	logic [10:0] ma = '0;
	logic [18:0] aa, last_a;
	logic loe, pdoe, rbn, rrq, wrq, rv, bsy, cea, wrej, stby, rdy, bootd, mm;
	int compares = 0, miscompares = 0, wr_cnt = 0, rej_cnt = 0;
	logic [31:0] rnd = 32'h78fd;
	lpc_flash_front lpc_flash_front_inst (.ref_clk(ref_clk), .rst_b(rst_b), .init_n(init_n),
		.mode_select(msel), .strap_identity_inputs(sid), .general_purpose_inputs(gpi),
		.top_block_lock_n(tbl), .write_protect_n(wp), .block_lock_bits(locks), .lclk(lclk),
		.lframe_n(lfr), .lad_in(li), .lad_out(lo), .lad_oe_n(loe), .multiplexed_address_port(ma),
		.row_col_select(rc), .oe_n(oe_n), .we_n(we_n), .parallel_data_in(pdi),
		.parallel_data_out(pdo), .parallel_data_oe_n(pdoe), .ready_busy_n(rbn),
		.array_rd_req(rrq), .array_wr_req(wrq), .array_addr(aa), .array_wr_data(awd),
		.array_rd_data(rdat), .array_rd_valid(rv), .array_busy(bsy), .chip_erase_allowed(cea),
		.write_rejected(wrej), .standby(stby), .ready_state(rdy), .boot_device(bootd),
		.mux_mode(mm));
	array_core_model array_core_model_inst (.ref_clk(ref_clk), .rd_req(rrq), .wr_req(wrq),
		.addr(aa), .delay(dly), .rd_data(rdat), .rd_valid(rv), .busy(bsy));
	// ***
	// Clock, monitor, helpers
	// ***
	// 200 MHz system clock
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Pulses are one cycle wide, so tally them as they pass
	always @(posedge ref_clk) begin
		if (wrq) begin
			wr_cnt++;
			last_a = aa;
			last_d = awd;
		end
		if (wrej) begin
			rej_cnt++;
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic clk_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// One bus clock: six system clocks, nibble steady across the rise
	task automatic tick(input logic fr, input logic [3:0] nib);
		lclk <= 1'b0;
		lfr <= fr;
		li <= nib;
		clk_n(3);
		lclk <= 1'b1;
		clk_n(3);
	endtask
	// Whole host-bus memory cycle; released lines carry inverted noise
	task automatic host_cyc(input logic [3:0] ct, input logic [31:0] a, input logic [7:0] wd,
		output logic [7:0] d, output logic drv);
		int i;
		d = '0;
		tick(1'b0, NIB_START);
		tick(1'b1, ct);
		for (i = 7; i >= 0; i--) begin
			tick(1'b1, a[i*4+:4]);
		end
		if (ct[CYC_DIR_BIT]) begin
			tick(1'b1, wd[3:0]);
			tick(1'b1, wd[7:4]);
		end
		tick(1'b1, NIB_TURN);
		drv = !loe;
		if (drv) begin
			tick(1'b1, ~li);
			for (i = 0; i < 200 && lo !== NIB_SYNC_OK; i++) begin
				check(32'(lo), 32'(NIB_SYNC_WAIT));
				tick(1'b1, ~li);
			end
			if (i == 200) begin
				miscompares++;
				final_report;
			end
			if (!ct[CYC_DIR_BIT]) begin
				tick(1'b1, ~li);
				d[3:0] = lo;
				tick(1'b1, ~li);
				d[7:4] = lo;
			end
			tick(1'b1, ~li);
			check(32'(lo), 32'(NIB_TURN));
			tick(1'b1, ~li);
			check(32'(loe), 32'h1);
		end
	endtask
	// Hang guard
	initial begin
		clk_n(90000);
		miscompares++;
		final_report;
	end
	// ***
	// Scenarios
	// ***
	initial begin
		logic [31:0] a;
		logic [7:0] d;
		logic drv, ok;
		logic [2:0] blk;
		int k, n, r;
		clk_n(12);
		rst_b <= 1'b1;
		clk_n(2);
		// Abort mid-address, host parks frame low with the abort nibble
		tick(1'b0, NIB_START);
		tick(1'b1, 4'h4);
		tick(1'b1, 4'h0);
		tick(1'b0, 4'h3);
		check(32'({loe, rdy}), 32'h2);
		tick(1'b0, NIB_ABORT);
		check(32'({loe, rdy}), 32'h3);
		$display("abort done");
		// Array reads, prompt then slow core
		for (k = 0; k < 2; k++) begin
			rnd = lfsr(rnd);
			dly <= k ? 8'h28 : 8'h01;
			a = {5'h0, sid, 1'b1, 3'h0, rnd[18:0]};
			host_cyc(4'h4, a, '0, d, drv);
			check(32'(d), 32'(a[7:0] ^ 8'h5a));
		end
		$display("array reads done");
		// Every protection combination on boot and ordinary blocks
		for (k = 0; k < 16; k++) begin
			rnd = lfsr(rnd);
			blk = k[0] ? BOOT_BLK : rnd[2:0] % 3'h7;
			tbl <= k[1];
			wp <= k[2];
			locks <= k[3] ? 8'h01 << blk : 8'h00;
			a = {5'h0, sid, 1'b1, 3'h0, blk, rnd[31:16]};
			n = wr_cnt;
			r = rej_cnt;
			host_cyc(4'h6, a, rnd[15:8], d, drv);
			ok = !k[3] && (k[0] ? k[1] : k[2]);
			check(32'(wr_cnt - n), 32'(ok));
			check(32'(rej_cnt - r), 32'(!ok));
			if (ok) check(32'({last_a, last_d}), 32'({a[18:0], rnd[15:8]}));
		end
		$display("protection done");
		// Parallel mode after a second reset: write, busy, read
		msel <= 1'b1;
		rst_b <= 1'b0;
		clk_n(3);
		rst_b <= 1'b1;
		clk_n(3);
		check(32'({mm, cea}), 32'h3);
		rnd = lfsr(rnd);
		dly <= 8'h06;
		rc <= 1'b1;
		ma <= rnd[10:0];
		clk_n(1);
		rc <= 1'b0;
		ma <= rnd[21:11];
		clk_n(2);
		we_n <= 1'b0;
		pdi <= rnd[29:22];
		clk_n(2);
		n = wr_cnt;
		we_n <= 1'b1;
		clk_n(4);
		check(32'(wr_cnt - n), 32'h1);
		check(32'({last_a, last_d}), 32'({rnd[18:11], rnd[10:0], rnd[29:22]}));
		check(32'(rbn), 32'h0);
		for (k = 0; k < 40 && rbn !== 1'b1; k++) clk_n(1);
		if (k == 40) begin
			miscompares++;
			final_report;
		end
		check(32'(rbn), 32'h1);
		oe_n <= 1'b0;
		for (k = 0; k < 40 && rv !== 1'b1; k++) clk_n(1);
		if (k == 40) begin
			miscompares++;
			final_report;
		end
		clk_n(2);
		check(32'({pdoe, pdo}), 32'(rnd[7:0] ^ 8'h5a));
		oe_n <= 1'b1;
		$display("parallel done");
		// Secondary reset, strap moved only while held
		init_n <= 1'b0;
		msel <= 1'b0;
		clk_n(4);
		check(32'(mm), 32'h0);
		init_n <= 1'b1;
		clk_n(3);
		// Register reads: own or foreign identity, mapped or unmapped offset
		for (k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			gpi <= rnd[4:0];
			sid <= rnd[8:5];
			clk_n(1);
			a = '0;
			a[26:23] = sid ^ {3'h0, k[0]};
			a[7:0] = k[1] ? 8'h10 : GPI_REG_OFS;
			host_cyc(4'h4, a, '0, d, drv);
			check(32'(drv), 32'(!k[0]));
			if (!k[0]) check(32'(d), 32'(k[1] ? REG_UNMAPPED : {3'h0, gpi}));
		end
		$display("register reads done");
		final_report;
	end
endmodule
